// ---- rtl/sltc_params.svh ----
`ifndef SLTC_PARAMS_SVH
`define SLTC_PARAMS_SVH

// ====================================================
// clock and link rates
`define SLTC_CLK_HZ        250000000
`define SLTC_BAUD_LO       38400
`define SLTC_BAUD_HI       230400
`define SLTC_WAKE_DEB_CYC  250
`define SLTC_TXD_LAG       3

// ====================================================
// register offsets (byte addresses)
`define SLTC_OFF_CTRL      8'h00
`define SLTC_OFF_STATUS    8'h04
`define SLTC_OFF_MASK      8'h08
`define SLTC_OFF_TXDATA    8'h0c
`define SLTC_OFF_RXDATA    8'h10
`define SLTC_OFF_LIVE      8'h14

// ====================================================
// control fields and reset value
`define SLTC_CTRL_W        5
`define SLTC_CTRL_RST      5'h00
`define SLTC_CTRL_DRIVE    0
`define SLTC_CTRL_RATE     1
`define SLTC_CTRL_LIMIT    2
`define SLTC_CTRL_PLAIN    3
`define SLTC_CTRL_GPIO     4

// ====================================================
// status / mask fields
`define SLTC_STAT_W        5
`define SLTC_STAT_RST      5'h00
`define SLTC_STAT_WAKE     0
`define SLTC_STAT_OC       1
`define SLTC_STAT_RXD      2
`define SLTC_STAT_RXERR    3
`define SLTC_STAT_TXD      4

// ====================================================
// bus answers
`define SLTC_RESP_OKAY     2'h0
`define SLTC_RESP_SLVERR   2'h2

`endif

// ---- rtl/sltc_pkg.sv ----
package sltc_pkg;

  // ====================================================
  // receiver sequencing
  typedef enum {SLTC_RX_IDLE, SLTC_RX_START, SLTC_RX_DATA} sltc_rx_t;

  // ====================================================
  // use of the serial data pins
  typedef enum {SLTC_MODE_LINK, SLTC_MODE_PLAIN} sltc_mode_t;

endpackage : sltc_pkg

// ---- rtl/sltc_link_if.sv ----
`timescale 1ns/100ps
`default_nettype none

interface sltc_link_if;
  logic dev_out;
  logic dev_oe;
  logic mst_out;
  logic mst_oe;
  wire  line;

  // released line rests at logic 1 (open circuit sits a full supply apart)
  assign line = (dev_oe ? dev_out : 1'b1) & (mst_oe ? mst_out : 1'b1);

  modport device (output dev_out, output dev_oe, input line);
  modport master (output mst_out, output mst_oe, input line);
endinterface : sltc_link_if

`default_nettype wire

// ---- rtl/sltc_uart_core.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "sltc_params.svh"

module sltc_uart_core
  import sltc_pkg::*;
#(
  parameter int DIV_LO = `SLTC_CLK_HZ / `SLTC_BAUD_LO,
  parameter int DIV_HI = `SLTC_CLK_HZ / `SLTC_BAUD_HI
) (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       rate_sel,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_valid,
  output logic            tx_ready,
  output logic            tx_line,
  input  wire logic       rx_line,
  output logic [7:0]      rx_data,
  output logic            rx_valid,
  output logic            rx_err
);
  localparam int CW = $clog2(DIV_LO + 1);

  logic [CW-1:0] bit_div;
  logic [CW-1:0] tx_cnt;
  logic [3:0]    tx_left;
  logic [10:0]   tx_shift;
  sltc_rx_t      rx_state;
  logic [CW-1:0] rx_cnt;
  logic [3:0]    rx_left;
  logic [8:0]    rx_shift;

  // ====================================================
  // bit period follows the rate pin
  assign bit_div = rate_sel ? CW'(DIV_HI - 1) : CW'(DIV_LO - 1);
  assign tx_line = tx_shift[0];

  // ====================================================
  // transmitter: start, 8 data lsb first, even parity, stop
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_ready <= 1'b1;
      tx_cnt   <= '0;
      tx_left  <= 4'h0;
      tx_shift <= 11'h7ff;
    end else if (tx_ready) begin
      if (tx_valid) begin
        tx_shift <= {1'b1, ^tx_data, tx_data, 1'b0};
        tx_left  <= 4'hb;
        tx_cnt   <= bit_div;
        tx_ready <= 1'b0;
      end
    end else if (tx_cnt == '0) begin
      // whole bit held at one level, no return inside it
      tx_shift <= {1'b1, tx_shift[10:1]};
      tx_left  <= tx_left - 4'h1;
      tx_cnt   <= bit_div;
      tx_ready <= (tx_left == 4'h1);
    end else begin
      tx_cnt <= tx_cnt - 1'b1;
    end
  end

  // ====================================================
  // receiver: mid-bit sampling; a start shorter than half a bit is a glitch
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_state <= SLTC_RX_IDLE;
      rx_cnt   <= '0;
      rx_left  <= 4'h0;
      rx_shift <= '0;
      rx_data  <= 8'h00;
      rx_valid <= 1'b0;
      rx_err   <= 1'b0;
    end else begin
      rx_valid <= 1'b0;
      unique case (rx_state)
        SLTC_RX_IDLE: begin
          if (!rx_line) begin
            rx_state <= SLTC_RX_START;
            rx_cnt   <= bit_div >> 1;
          end
        end
        SLTC_RX_START: begin
          if (rx_cnt != '0) begin
            rx_cnt <= rx_cnt - 1'b1;
          end else if (rx_line) begin
            rx_state <= SLTC_RX_IDLE;
          end else begin
            rx_state <= SLTC_RX_DATA;
            rx_cnt   <= bit_div;
            rx_left  <= 4'ha;
          end
        end
        SLTC_RX_DATA: begin
          if (rx_cnt != '0) begin
            rx_cnt <= rx_cnt - 1'b1;
          end else if (rx_left == 4'h1) begin
            // last sample is the stop bit; parity must leave an even count
            rx_state <= SLTC_RX_IDLE;
            rx_data  <= rx_shift[7:0];
            rx_err   <= ~rx_line | (^rx_shift);
            rx_valid <= 1'b1;
          end else begin
            rx_shift <= {rx_line, rx_shift[8:1]};
            rx_cnt   <= bit_div;
            rx_left  <= rx_left - 4'h1;
          end
        end
      endcase
    end
  end
endmodule : sltc_uart_core

`default_nettype wire

// ---- rtl/sltc_device.sv ----
// Decided for this implementation: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "sltc_params.svh"

module sltc_device
  import sltc_pkg::*;
#(
  parameter int ADDR_W       = 8,
  parameter int DIV_LO       = `SLTC_CLK_HZ / `SLTC_BAUD_LO,
  parameter int DIV_HI       = `SLTC_CLK_HZ / `SLTC_BAUD_HI,
  parameter int WAKE_DEB_CYC = `SLTC_WAKE_DEB_CYC
) (
  input  wire logic              MCLK,
  input  wire logic              RST_B,
  input  wire logic [ADDR_W-1:0] AWADDR,
  input  wire logic              AWVALID,
  output logic                   AWREADY,
  input  wire logic [31:0]       WDATA,
  input  wire logic [3:0]        WSTRB,
  input  wire logic              WVALID,
  output logic                   WREADY,
  output logic [1:0]             BRESP,
  output logic                   BVALID,
  input  wire logic              BREADY,
  input  wire logic [ADDR_W-1:0] ARADDR,
  input  wire logic              ARVALID,
  output logic                   ARREADY,
  output logic [31:0]            RDATA,
  output logic [1:0]             RRESP,
  output logic                   RVALID,
  input  wire logic              RREADY,
  input  wire logic              TRANSCEIVER_SUPPLY_LOW,
  input  wire logic              IO_SUPPLY_LOW,
  input  wire logic              OC_SENSE_HIGH_RANGE,
  input  wire logic              OC_SENSE_LOW_RANGE,
  output logic                   WAKE_REQUEST_OUT,
  output logic                   OVERCURRENT_FLAG_OUT,
  output logic                   IRQ,
  sltc_link_if.device            LINK
);
  localparam int DW = $clog2(WAKE_DEB_CYC + 1);

  logic [ADDR_W-1:0]      aw_addr;
  logic                   aw_hold;
  logic [7:0]             w_byte;
  logic                   w_lane0;
  logic                   w_hold;
  logic                   do_wr;
  logic                   wr_hit;
  logic [`SLTC_CTRL_W-1:0] ctrl;
  logic [`SLTC_STAT_W-1:0] status;
  logic [`SLTC_STAT_W-1:0] mask;
  logic [`SLTC_STAT_W-1:0] ev;
  logic [7:0]             rx_byte;
  logic                   tx_go;
  logic [7:0]             tx_byte;
  logic                   tx_ready;
  logic                   tx_ready_d;
  logic                   uart_tx;
  logic [7:0]             uart_rx_data;
  logic                   uart_rx_valid;
  logic                   uart_rx_err;
  sltc_mode_t             mode;
  logic                   port_bit_tx_drive;
  logic                   port_bit_rate_sel;
  logic                   serial_tx_pin;
  logic                   serial_rx_pin;
  logic                   drv_on;
  logic                   wake_off;
  logic [`SLTC_TXD_LAG-1:0] txd_hist;
  logic                   txd_moved;
  logic                   line_ref;
  logic [DW-1:0]          wk_cnt;
  logic [1:0]             ev_s1;
  logic [1:0]             ev_s2;
  logic [1:0]             ev_s3;

  // ====================================================
  // register bus: write channel
  assign do_wr  = aw_hold & w_hold & ~BVALID;
  assign wr_hit = (aw_addr == ADDR_W'(`SLTC_OFF_CTRL))   | (aw_addr == ADDR_W'(`SLTC_OFF_STATUS)) |
                  (aw_addr == ADDR_W'(`SLTC_OFF_MASK))   | (aw_addr == ADDR_W'(`SLTC_OFF_TXDATA)) |
                  (aw_addr == ADDR_W'(`SLTC_OFF_RXDATA)) | (aw_addr == ADDR_W'(`SLTC_OFF_LIVE));

  // address and data taken in either order; response after both
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      AWREADY <= 1'b1;
      WREADY  <= 1'b1;
      aw_hold <= 1'b0;
      w_hold  <= 1'b0;
      aw_addr <= '0;
      w_byte  <= 8'h00;
      w_lane0 <= 1'b0;
      BVALID  <= 1'b0;
      BRESP   <= `SLTC_RESP_OKAY;
    end else begin
      if (AWVALID && AWREADY) begin
        aw_hold <= 1'b1;
        aw_addr <= AWADDR;
        AWREADY <= 1'b0;
      end
      if (WVALID && WREADY) begin
        w_hold  <= 1'b1;
        w_byte  <= WDATA[7:0];
        w_lane0 <= WSTRB[0];
        WREADY  <= 1'b0;
      end
      if (do_wr) begin
        aw_hold <= 1'b0;
        w_hold  <= 1'b0;
        BVALID  <= 1'b1;
        BRESP   <= wr_hit ? `SLTC_RESP_OKAY : `SLTC_RESP_SLVERR;
      end
      if (BVALID && BREADY) begin
        BVALID  <= 1'b0;
        AWREADY <= 1'b1;
        WREADY  <= 1'b1;
      end
    end
  end

  // ====================================================
  // register bus: read channel, no read side effects
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      ARREADY <= 1'b1;
      RVALID  <= 1'b0;
      RDATA   <= 32'h0000_0000;
      RRESP   <= `SLTC_RESP_OKAY;
    end else if (ARVALID && ARREADY) begin
      ARREADY <= 1'b0;
      RVALID  <= 1'b1;
      RRESP   <= `SLTC_RESP_OKAY;
      RDATA   <= 32'h0000_0000;
      case (ARADDR)
        ADDR_W'(`SLTC_OFF_CTRL):   RDATA[`SLTC_CTRL_W-1:0] <= ctrl;
        ADDR_W'(`SLTC_OFF_STATUS): RDATA[`SLTC_STAT_W-1:0] <= status;
        ADDR_W'(`SLTC_OFF_MASK):   RDATA[`SLTC_STAT_W-1:0] <= mask;
        ADDR_W'(`SLTC_OFF_TXDATA): RDATA[0] <= ~tx_ready;
        ADDR_W'(`SLTC_OFF_RXDATA): RDATA[7:0] <= rx_byte;
        ADDR_W'(`SLTC_OFF_LIVE):   RDATA[4:0] <= {wake_off, serial_rx_pin, LINK.dev_oe, ~tx_ready, LINK.line};
        default:                   RRESP <= `SLTC_RESP_SLVERR;
      endcase
    end else if (RVALID && RREADY) begin
      RVALID  <= 1'b0;
      ARREADY <= 1'b1;
    end
  end

  // ====================================================
  // control and mask; only byte lane 0 carries fields
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      ctrl <= `SLTC_CTRL_RST;
      mask <= `SLTC_STAT_RST;
    end else if (do_wr && w_lane0) begin
      if (aw_addr == ADDR_W'(`SLTC_OFF_CTRL)) ctrl <= w_byte[`SLTC_CTRL_W-1:0];
      if (aw_addr == ADDR_W'(`SLTC_OFF_MASK)) mask <= w_byte[`SLTC_STAT_W-1:0];
    end
  end

  // sticky status, write one to clear; a new event beats the clear
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      status <= `SLTC_STAT_RST;
      IRQ    <= 1'b0;
    end else begin
      if (do_wr && w_lane0 && aw_addr == ADDR_W'(`SLTC_OFF_STATUS)) begin
        status <= (status & ~w_byte[`SLTC_STAT_W-1:0]) | ev;
      end else begin
        status <= status | ev;
      end
      IRQ <= |(status & mask);
    end
  end

  // ====================================================
  // serial port zero: a write while busy is dropped, software polls busy
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      tx_go      <= 1'b0;
      tx_byte    <= 8'h00;
      tx_ready_d <= 1'b1;
      rx_byte    <= 8'h00;
    end else begin
      tx_go      <= do_wr && w_lane0 && aw_addr == ADDR_W'(`SLTC_OFF_TXDATA) && tx_ready && !tx_go;
      tx_ready_d <= tx_ready;
      if (do_wr && w_lane0 && aw_addr == ADDR_W'(`SLTC_OFF_TXDATA)) tx_byte <= w_byte;
      if (uart_rx_valid) rx_byte <= uart_rx_data;
    end
  end

  assign port_bit_tx_drive = ctrl[`SLTC_CTRL_DRIVE];
  assign port_bit_rate_sel = ctrl[`SLTC_CTRL_RATE];
  assign mode = ctrl[`SLTC_CTRL_PLAIN] ? SLTC_MODE_PLAIN : SLTC_MODE_LINK;

  sltc_uart_core #(
    .DIV_LO (DIV_LO),
    .DIV_HI (DIV_HI)
  ) u_uart (
    .clk      (MCLK),
    .rst_b    (RST_B),
    .rate_sel (port_bit_rate_sel),
    .tx_data  (tx_byte),
    .tx_valid (tx_go),
    .tx_ready (tx_ready),
    .tx_line  (uart_tx),
    .rx_line  ((mode == SLTC_MODE_LINK) ? serial_rx_pin : 1'b1),
    .rx_data  (uart_rx_data),
    .rx_valid (uart_rx_valid),
    .rx_err   (uart_rx_err)
  );

  // pin owner chosen by mode
  assign serial_tx_pin = (mode == SLTC_MODE_LINK) ? uart_tx : ctrl[`SLTC_CTRL_GPIO];

  // ====================================================
  // transceiver: line driver, receive pin, overcurrent
  // the wake pulse itself cuts the driver, so shutoff does not wait for the latch
  assign drv_on = port_bit_tx_drive & ~wake_off & ~WAKE_REQUEST_OUT & ~OVERCURRENT_FLAG_OUT &
                  ~TRANSCEIVER_SUPPLY_LOW & ~IO_SUPPLY_LOW;

  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      LINK.dev_oe          <= 1'b0;
      LINK.dev_out         <= 1'b1;
      serial_rx_pin        <= 1'b1;
      OVERCURRENT_FLAG_OUT <= 1'b0;
    end else begin
      LINK.dev_oe          <= drv_on;
      LINK.dev_out         <= serial_tx_pin;
      serial_rx_pin        <= LINK.line;
      OVERCURRENT_FLAG_OUT <= ctrl[`SLTC_CTRL_LIMIT] ? OC_SENSE_LOW_RANGE : OC_SENSE_HIGH_RANGE;
    end
  end

  // ====================================================
  // wake detection; txd history covers the echo lag through driver and receiver
  assign txd_moved = (serial_tx_pin != txd_hist[0]) | (txd_hist != {`SLTC_TXD_LAG{txd_hist[0]}});

  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      txd_hist         <= '1;
      line_ref         <= 1'b1;
      wk_cnt           <= '0;
      WAKE_REQUEST_OUT <= 1'b0;
    end else begin
      txd_hist         <= {txd_hist[`SLTC_TXD_LAG-2:0], serial_tx_pin};
      WAKE_REQUEST_OUT <= 1'b0;
      if (txd_moved) begin
        line_ref <= serial_rx_pin;
        wk_cnt   <= '0;
      end else if (serial_rx_pin == line_ref) begin
        wk_cnt <= '0;
      end else if (wk_cnt == DW'(WAKE_DEB_CYC - 1)) begin
        WAKE_REQUEST_OUT <= 1'b1;
        line_ref         <= serial_rx_pin;
        wk_cnt           <= '0;
      end else begin
        wk_cnt <= wk_cnt + 1'b1;
      end
    end
  end

  // transmitter stays off after a wake until software drops drive enable
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      wake_off <= 1'b0;
    end else if (WAKE_REQUEST_OUT) begin
      wake_off <= 1'b1;
    end else if (!port_bit_tx_drive) begin
      wake_off <= 1'b0;
    end
  end

  // ====================================================
  // wake and overcurrent flags: two-stage sync, then rising-edge detect
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      ev_s1 <= 2'h0;
      ev_s2 <= 2'h0;
      ev_s3 <= 2'h0;
    end else begin
      ev_s1 <= {OVERCURRENT_FLAG_OUT, WAKE_REQUEST_OUT};
      ev_s2 <= ev_s1;
      ev_s3 <= ev_s2;
    end
  end

  always_comb begin
    ev                   = '0;
    ev[`SLTC_STAT_WAKE]  = ev_s2[0] & ~ev_s3[0];
    ev[`SLTC_STAT_OC]    = ev_s2[1] & ~ev_s3[1];
    ev[`SLTC_STAT_RXD]   = uart_rx_valid;
    ev[`SLTC_STAT_RXERR] = uart_rx_valid & uart_rx_err;
    ev[`SLTC_STAT_TXD]   = tx_ready & ~tx_ready_d;
  end
endmodule : sltc_device

`default_nettype wire

// ---- rtl/sltc_master.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "sltc_params.svh"

module sltc_master
  import sltc_pkg::*;
#(
  parameter int DIV_LO = `SLTC_CLK_HZ / `SLTC_BAUD_LO,
  parameter int DIV_HI = `SLTC_CLK_HZ / `SLTC_BAUD_HI
) (
  input  wire logic       MCLK,
  input  wire logic       RST_B,
  input  wire logic       RATE_SELECT,
  input  wire logic [7:0] TX_DATA,
  input  wire logic       TX_VALID,
  output logic            TX_READY,
  output logic [7:0]      RX_DATA,
  output logic            RX_VALID,
  output logic            RX_ERROR,
  sltc_link_if.master     LINK
);
  logic uart_tx;
  logic line_in;

  // ====================================================
  // master drives only while a character is on its way; enable follows busy
  // so the first driven bit is the start bit, not the idle level
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      LINK.mst_oe  <= 1'b0;
      LINK.mst_out <= 1'b1;
      line_in      <= 1'b1;
    end else begin
      LINK.mst_oe  <= ~TX_READY;
      LINK.mst_out <= uart_tx;
      line_in      <= LINK.mst_oe ? 1'b1 : LINK.line; // own echo is ignored
    end
  end

  sltc_uart_core #(
    .DIV_LO (DIV_LO),
    .DIV_HI (DIV_HI)
  ) u_uart (
    .clk      (MCLK),
    .rst_b    (RST_B),
    .rate_sel (RATE_SELECT),
    .tx_data  (TX_DATA),
    .tx_valid (TX_VALID),
    .tx_ready (TX_READY),
    .tx_line  (uart_tx),
    .rx_line  (line_in),
    .rx_data  (RX_DATA),
    .rx_valid (RX_VALID),
    .rx_err   (RX_ERROR)
  );
endmodule : sltc_master

`default_nettype wire

// ---- sim/sltc_props.sv ----
`timescale 1ns/100ps
`default_nettype none

// ==========================================================
// link checks, watching the shared line and the event pins
module sltc_props (
  input wire logic MCLK,
  input wire logic RST_B,
  input wire logic dev_out,
  input wire logic dev_oe,
  input wire logic mst_out,
  input wire logic mst_oe,
  input wire logic line,
  input wire logic TRANSCEIVER_SUPPLY_LOW,
  input wire logic IO_SUPPLY_LOW,
  input wire logic OVERCURRENT_FLAG_OUT,
  input wire logic WAKE_REQUEST_OUT
);
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!RST_B);

  // wake shutoff is latched, so a single quiet cycle is not enough
  sequence s_wake_hit;
    WAKE_REQUEST_OUT;
  endsequence
  sequence s_off4;
    !dev_oe [*4];
  endsequence

  // bit times here assume both dividers are at least 9 cycles
  a_supply_off: assert property ((TRANSCEIVER_SUPPLY_LOW || IO_SUPPLY_LOW) |=> !dev_oe)
    else $error("driver on while a supply is low");
  a_oc_drive_off: assert property (OVERCURRENT_FLAG_OUT && $past(OVERCURRENT_FLAG_OUT) |-> !dev_oe)
    else $error("driver on during overcurrent");
  a_wake_shutoff: assert property (s_wake_hit |=> s_off4)
    else $error("driver on after wake");
  a_wake_pulse_once: assert property (s_wake_hit |=> !WAKE_REQUEST_OUT)
    else $error("wake request longer than one cycle");
  a_start_bit_low: assert property ($rose(mst_oe) |-> !mst_out)
    else $error("frame does not open with a low bit");
  a_bit_held: assert property (mst_oe && $changed(mst_out) |=> $stable(mst_out) [*8])
    else $error("bit level changed inside a bit time");
  a_stop_bit_high: assert property ($fell(mst_oe) |-> $past(mst_out))
    else $error("frame released without a high stop bit");
  a_line_level: assert property (line == !((dev_oe && !dev_out) || (mst_oe && !mst_out)))
    else $error("line level not set by the enabled drivers");
endmodule : sltc_props

`default_nettype wire

// ---- sim/tb.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "sltc_params.svh"
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin failures++; \
  $display("MISMATCH %s exp %h got %h", n, e, g); end end

module tb;
  localparam int DIV_LO = 40;
  localparam int DIV_HI = 12;
  localparam logic [7:0] CTRL = `SLTC_OFF_CTRL;
  localparam logic [7:0] STAT = `SLTC_OFF_STATUS;
  localparam logic [7:0] MASK = `SLTC_OFF_MASK;
  localparam logic [7:0] LIVE = `SLTC_OFF_LIVE;

  logic        mclk, rst_b, awvalid, wvalid, bready, arvalid, rready, tx_valid, rate;
  logic        ts_low, io_low, oc_hi, oc_lo, m_err;
  logic        awready, wready, bvalid, arready, rvalid, wake, ocf, irq, tx_ready, rx_valid, rx_err;
  logic [7:0]  awaddr, araddr, tx_data, rx_data, m_byte;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  int          failures = 0, samples_checked = 0, m_cnt = 0, wk_cnt = 0, div, w;

  sltc_link_if sltc_link_if_i ();
  sltc_device #(.DIV_LO(DIV_LO), .DIV_HI(DIV_HI), .WAKE_DEB_CYC(8)) sltc_device_i (
    .MCLK(mclk), .RST_B(rst_b), .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready), .WDATA(wdata),
    .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp), .BVALID(bvalid), .BREADY(bready),
    .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid),
    .RREADY(rready), .TRANSCEIVER_SUPPLY_LOW(ts_low), .IO_SUPPLY_LOW(io_low), .OC_SENSE_HIGH_RANGE(oc_hi),
    .OC_SENSE_LOW_RANGE(oc_lo), .WAKE_REQUEST_OUT(wake), .OVERCURRENT_FLAG_OUT(ocf), .IRQ(irq),
    .LINK(sltc_link_if_i.device));
  sltc_master #(.DIV_LO(DIV_LO), .DIV_HI(DIV_HI)) sltc_master_i (
    .MCLK(mclk), .RST_B(rst_b), .RATE_SELECT(rate), .TX_DATA(tx_data), .TX_VALID(tx_valid),
    .TX_READY(tx_ready), .RX_DATA(rx_data), .RX_VALID(rx_valid), .RX_ERROR(rx_err),
    .LINK(sltc_link_if_i.master));
  sltc_props sltc_props_i (
    .MCLK(mclk), .RST_B(rst_b), .dev_out(sltc_link_if_i.dev_out), .dev_oe(sltc_link_if_i.dev_oe),
    .mst_out(sltc_link_if_i.mst_out), .mst_oe(sltc_link_if_i.mst_oe), .line(sltc_link_if_i.line),
    .TRANSCEIVER_SUPPLY_LOW(ts_low), .IO_SUPPLY_LOW(io_low), .OVERCURRENT_FLAG_OUT(ocf),
    .WAKE_REQUEST_OUT(wake));

  // ==========================================================
  // clock and event monitors
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  // pulses are counted here so a task busy elsewhere cannot miss them
  always @(posedge mclk) begin
    if (rx_valid === 1'b1) begin
      m_cnt <= m_cnt + 1;
      m_byte <= rx_data;
      m_err <= rx_err;
    end
    if (wake === 1'b1) begin
      wk_cnt <= wk_cnt + 1;
    end
  end

  // ==========================================================
  // register bus tasks
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    fork
      begin
        do @(posedge mclk); while (awready !== 1'b1);
        awvalid <= 1'b0;
      end
      begin
        do @(posedge mclk); while (wready !== 1'b1);
        wvalid <= 1'b0;
      end
    join
    do @(posedge mclk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    `CHK("write resp", `SLTC_RESP_OKAY, bresp)
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input logic [1:0] er);
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge mclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge mclk); while (rvalid !== 1'b1);
    rready <= 1'b0;
    `CHK("read resp", er, rresp)
    `CHK("read data", e, rdata & m)
  endtask : rd

  // ==========================================================
  // link tasks: device send is watched bit by bit on the wire
  task automatic dev_send(input logic [7:0] b);
    logic [10:0] f;
    int n, w0;
    f = {1'b1, ^b, b, 1'b0};
    n = m_cnt;
    w0 = wk_cnt;
    wr(`SLTC_OFF_TXDATA, {24'h0, b});
    do @(posedge mclk); while (sltc_link_if_i.line !== 1'b0);
    repeat (div / 2) @(posedge mclk);
    for (int k = 0; k < 11; k++) begin
      `CHK("line bit", f[k], sltc_link_if_i.line)
      repeat (div) @(posedge mclk);
    end
    `CHK("master count", n + 1, m_cnt)
    `CHK("master byte", b, m_byte)
    `CHK("master parity", 1'b0, m_err)
    `CHK("wake count", w0, wk_cnt)
  endtask : dev_send

  task automatic mst_send(input logic [7:0] b);
    @(posedge mclk);
    tx_data <= b;
    tx_valid <= 1'b1;
    do @(posedge mclk); while (tx_ready !== 1'b1);
    tx_valid <= 1'b0;
    repeat (12 * div) @(posedge mclk);
  endtask : mst_send

  task automatic end_of_test();
    if (failures == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_of_test

  // ==========================================================
  // main sequence
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, tx_valid, rate, ts_low, io_low, oc_hi, oc_lo} = '0;
    {awaddr, araddr, tx_data, wdata} = '0;
    wstrb = 4'hf;
    rst_b = 1'b0;
    repeat (6) @(posedge mclk);
    rst_b <= 1'b1;
    `CHK("driver after reset", 1'b0, sltc_link_if_i.dev_oe)
    rd(CTRL, 32'h1f, 32'h0, 2'h0);
    rd(STAT, 32'h1f, 32'h0, 2'h0);
    rd(MASK, 32'h1f, 32'h0, 2'h0);
    rd(8'h18, 32'h0, 32'h0, `SLTC_RESP_SLVERR);
    // both rates, each direction; drive off first clears any wake shutoff
    for (int r = 0; r < 2; r++) begin
      div = r ? DIV_HI : DIV_LO;
      rate <= r[0];
      wr(CTRL, 32'h0);
      wr(CTRL, {30'h0, r[0], 1'b1});
      dev_send(r ? 8'h3c : 8'h96);
      rd(`SLTC_OFF_TXDATA, 32'h1, 32'h0, 2'h0);
      wr(CTRL, {30'h0, r[0], 1'b0});
      wr(STAT, 32'h1f);
      mst_send(r ? 8'h01 : 8'ha7);
      rd(`SLTC_OFF_RXDATA, 32'hff, r ? 32'h01 : 32'ha7, 2'h0);
      rd(STAT, 32'hc, 32'h4, 2'h0);
    end
    wr(CTRL, 32'h0);
    wr(CTRL, 32'h1);
    for (int s = 0; s < 2; s++) begin
      {io_low, ts_low} <= s ? 2'b10 : 2'b01;
      repeat (3) @(posedge mclk);
      `CHK("driver when supply low", 1'b0, sltc_link_if_i.dev_oe)
      rd(LIVE, 32'h4, 32'h0, 2'h0);
      {io_low, ts_low} <= 2'b00;
      repeat (3) @(posedge mclk);
      `CHK("driver enabled", 1'b1, sltc_link_if_i.dev_oe)
    end
    // every limit select against every sense combination
    for (int i = 0; i < 8; i++) begin
      wr(CTRL, {29'h0, i[2], 2'b01});
      {oc_hi, oc_lo} <= i[1:0];
      repeat (3) @(posedge mclk);
      `CHK("overcurrent flag", i[2] ? i[0] : i[1], ocf)
      `CHK("driver on overcurrent", ~(i[2] ? i[0] : i[1]), sltc_link_if_i.dev_oe)
      {oc_hi, oc_lo} <= 2'b00;
    end
    repeat (3) @(posedge mclk);
    `CHK("irq masked", 1'b0, irq)
    wr(MASK, 32'h2);
    repeat (3) @(posedge mclk);
    `CHK("irq unmasked", 1'b1, irq)
    wr(STAT, 32'h2);
    repeat (3) @(posedge mclk);
    `CHK("irq cleared", 1'b0, irq)
    rd(STAT, 32'h2, 32'h0, 2'h0);
    // plain mode: tx pin follows the port level bit
    wr(CTRL, 32'h19);
    repeat (4) @(posedge mclk);
    `CHK("plain high", 1'b1, sltc_link_if_i.line)
    wr(CTRL, 32'h09);
    repeat (4) @(posedge mclk);
    `CHK("plain low", 1'b0, sltc_link_if_i.line)
    // long low from the master while the device holds its txd steady
    wr(CTRL, 32'h0);
    wr(STAT, 32'h1f);
    wr(MASK, 32'h1);
    wr(CTRL, 32'h1);
    rate <= 1'b0;
    div = DIV_LO;
    w = wk_cnt;
    mst_send(8'h00);
    `CHK("wake seen", 1'b1, wk_cnt > w)
    `CHK("driver after wake", 1'b0, sltc_link_if_i.dev_oe)
    rd(LIVE, 32'h10, 32'h10, 2'h0);
    rd(STAT, 32'h1, 32'h1, 2'h0);
    `CHK("wake irq", 1'b1, irq)
    wr(STAT, 32'h1);
    wr(CTRL, 32'h0);
    repeat (3) @(posedge mclk);
    `CHK("wake irq cleared", 1'b0, irq)
    rd(LIVE, 32'h10, 32'h0, 2'h0);
    end_of_test();
  end

  // hang guard, well above the few thousand cycles the tests need
  initial begin
    repeat (30000) @(posedge mclk);
    failures++;
    end_of_test();
  end
endmodule : tb

`default_nettype wire
